// File: inc/role_dir_pkg.sv
// package: constants, types and register map for the serial bus role/direction block
// assumes: one clock domain, plain register port with one-cycle read latency
package role_dir_pkg;

  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;
  localparam logic [3:0]  MAIN_CTRL_OFF   = 4'h0;
  localparam logic [3:0]  AUX_CTRL_OFF    = 4'h1;
  localparam logic [3:0]  STATUS_OFF      = 4'h2;
  localparam logic [3:0]  IRQ_STAT_OFF    = 4'h3;
  localparam logic [3:0]  IRQ_EN_OFF      = 4'h4;
  localparam logic [3:0]  IRQ_CLR_OFF     = 4'h5;
  localparam logic [3:0]  OWN_ADDR_OFF    = 4'h6;
  localparam logic [3:0]  TX_DATA_OFF     = 4'h7;
  localparam logic [3:0]  RX_DATA_OFF     = 4'h8;

  // main control fields
  localparam int          DIR_BIT_POS     = 6;
  localparam int          MST_BIT_POS     = 7;
  localparam int          START_BIT_POS   = 5;
  localparam int          STOP_BIT_POS    = 4;
  // aux control fields
  localparam int          EN_BIT_POS      = 0;
  localparam int          RST_BIT_POS     = 1;
  localparam int          FREE_BIT_POS    = 2;
  // status fields
  localparam int          BB_POS          = 0;
  localparam int          AAS_POS         = 1;
  localparam int          AL_POS          = 2;
  localparam int          PROT_POS        = 3;
  localparam int          DONE_POS        = 4;
  localparam int          NACK_POS        = 5;
  // interrupt event bits
  localparam int          EV_W            = 5;
  localparam int          EV_START        = 0;
  localparam int          EV_STOP         = 1;
  localparam int          EV_AL           = 2;
  localparam int          EV_BYTE         = 3;
  localparam int          EV_BLOCKED      = 4;

  localparam logic [7:0]  MAIN_RESET      = 8'h00;
  localparam logic [7:0]  AUX_RESET       = 8'h00;
  localparam logic [6:0]  OWN_ADDR_RESET  = 7'h50;

  localparam int          CLK_MHZ         = 50;
  localparam int          SCL_HALF_NS     = 2500;
  localparam int          SCL_HALF_CYC    = (SCL_HALF_NS * CLK_MHZ) / 1000;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_BITS  = 3'b010,
    ST_ACK   = 3'b011,
    ST_STOP  = 3'b100
  } mst_state_t;

endpackage

// File: core/role_dir_ctrl.sv
// role and transfer direction control for a two-wire serial bus interface
// assumes: bus pins are asynchronous and synchronised here; open-drain wire resolved outside
//
// Function
// - direction 0: receive data driven onto the data line by the transmitter
// - direction 1: transmit data onto the data line in step with bus clock
// - slave, addressed format, address match and read bit 1: direction set to 1
// - direction cleared on lost arbitration, stop, start, blocked start, disable, reset
// - in slave mode, start or missing acknowledge also clears direction
// - master select 0: slave, receives start/stop and follows master clock
// - master select 1: generates start, stop and every clock pulse
// - after lost arbitration, master select cleared once the byte completes
// - master select cleared on stop, start, blocked start, reset bit, disable
// - start on free bus sets master select, direction and busy together
// - writes to master select and direction ignored while protection is active
// - protection active from busy rising edge until slave address received
`timescale 1ns/1ps
module role_dir_ctrl
  import role_dir_pkg::*;
#(
  parameter int HALF_CYC = SCL_HALF_CYC
) (
  input  wire logic                      clock_in,
  input  wire logic                      reset_in,
  input  wire logic                      clk_en_in,
  input  wire role_dir_pkg::reg_req_t    req_in,
  output logic [role_dir_pkg::DATA_W-1:0] rdata_out,
  input  wire role_dir_pkg::bus_pins_t   pins_in,
  output role_dir_pkg::bus_pins_t        pins_oe_n_out,
  output logic                           irq_out
);
  import role_dir_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and bus condition detection
  // ----------------------------------------------------------------
  bus_pins_t meta_q, sync_q, prev_q;
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else if (clk_en_in) begin
      meta_q <= pins_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  wire scl_rise  = sync_q.scl & ~prev_q.scl;
  wire scl_fall  = ~sync_q.scl & prev_q.scl;
  wire start_det = sync_q.scl & prev_q.scl & prev_q.sda & ~sync_q.sda;
  wire stop_det  = sync_q.scl & prev_q.scl & ~prev_q.sda & sync_q.sda;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic            mst_q, dir_q, bb_q, aas_q, al_q, prot_q, nack_q, done_q;
  logic            en_q, free_q, start_req_q, stop_req_q, al_pend_q;
  logic [6:0]      own_q;
  logic [7:0]      tx_q, rx_q, sh_q;
  logic [3:0]      bitn_q;
  logic            addr_phase_q, drive_sda_q, drive_scl_q;
  logic [EV_W-1:0] ist_q, ien_q;
  logic [15:0]     hc_q;
  logic [DATA_W-1:0] rdata_q;
  mst_state_t      st_q;

  wire wr_main   = req_in.wr & (req_in.addr == MAIN_CTRL_OFF);
  wire wr_aux    = req_in.wr & (req_in.addr == AUX_CTRL_OFF);
  wire soft_rst  = wr_aux & req_in.wdata[RST_BIT_POS];
  wire disable_w = wr_aux & ~req_in.wdata[EN_BIT_POS];
  wire kill      = soft_rst | disable_w | ~en_q;
  // blocked start: software start while busy or protection is active
  wire want_start = wr_main & req_in.wdata[START_BIT_POS] & req_in.wdata[MST_BIT_POS];
  wire blocked    = want_start & (bb_q | prot_q);
  wire go_start   = want_start & ~blocked & en_q & ~soft_rst;
  // eighth data bit done at this fall; ninth (acknowledge) clock ends the byte
  wire byte_rcvd  = (bitn_q == 4'h8) & scl_fall;
  wire byte_end   = (bitn_q == 4'h9) & scl_fall;
  wire addr_done  = addr_phase_q & byte_rcvd;
  wire addr_match = (sh_q[7:1] == own_q);
  wire ack_me     = addr_phase_q ? addr_match : (aas_q | mst_q);

  // ----------------------------------------------------------------
  // role and direction bits
  // ----------------------------------------------------------------
  wire clr_both = kill | stop_det | (start_det & ~(go_start | st_q == ST_START)) | blocked;
  wire al_event = mst_q & drive_sda_q == 1'b0 & sync_q.scl & scl_rise & ~sync_q.sda & dir_q & (bitn_q < 4'h8);

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      mst_q     <= 1'b0;
      dir_q     <= 1'b0;
      bb_q      <= 1'b0;
      prot_q    <= 1'b0;
      al_q      <= 1'b0;
      al_pend_q <= 1'b0;
    end else if (clk_en_in) begin
      if (go_start) begin
        mst_q  <= 1'b1;
        dir_q  <= 1'b1;
        bb_q   <= 1'b1;
        prot_q <= 1'b1;
      end else begin
        if (clr_both | al_event) dir_q <= 1'b0;
        else if (~mst_q & (start_det | nack_q)) dir_q <= 1'b0;
        else if (~mst_q & ~free_q & addr_done & addr_match & sh_q[0]) dir_q <= 1'b1;
        else if (wr_main & ~prot_q) dir_q <= req_in.wdata[DIR_BIT_POS];
        if (clr_both) mst_q <= 1'b0;
        else if (al_pend_q & byte_end) mst_q <= 1'b0;
        else if (wr_main & ~prot_q & ~bb_q) mst_q <= req_in.wdata[MST_BIT_POS];
        if (kill | stop_det) bb_q <= 1'b0;
        else if (start_det) bb_q <= 1'b1;
        if (kill | addr_done) prot_q <= 1'b0;
        else if (start_det & ~bb_q) prot_q <= 1'b1;
      end
      if (kill | stop_det) al_pend_q <= 1'b0;
      else if (al_event) al_pend_q <= 1'b1;
      if (kill) al_q <= 1'b0;
      else if (al_event) al_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // shift engine: slave follows bus clock, master makes it
  // ----------------------------------------------------------------
  wire hc_tick = (hc_q == 16'(HALF_CYC - 1));
  wire shift_in_bit = (bitn_q < 4'h8) & scl_rise;
  wire at_boundary  = stop_req_q & (bitn_q == 4'h0) & drive_scl_q;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      st_q         <= ST_IDLE;
      hc_q         <= 16'h0000;
      drive_scl_q  <= 1'b0;
      drive_sda_q  <= 1'b0;
      sh_q         <= 8'h00;
      bitn_q       <= 4'h0;
      addr_phase_q <= 1'b0;
      aas_q        <= 1'b0;
      nack_q       <= 1'b0;
      done_q       <= 1'b0;
      rx_q         <= 8'h00;
      start_req_q  <= 1'b0;
      stop_req_q   <= 1'b0;
    end else if (clk_en_in) begin
      hc_q <= (hc_tick | st_q == ST_IDLE) ? 16'h0000 : hc_q + 16'h0001;
      nack_q <= 1'b0;
      if (wr_main & req_in.wdata[STOP_BIT_POS] & mst_q) stop_req_q <= 1'b1;
      if (start_det | kill) begin
        bitn_q       <= 4'h0;
        addr_phase_q <= 1'b1;
        aas_q        <= 1'b0;
        sh_q         <= tx_q;
        drive_sda_q  <= 1'b0;
      end else begin
        if (shift_in_bit & ~dir_q) sh_q <= {sh_q[6:0], sync_q.sda};
        if (scl_rise & bitn_q < 4'h9) bitn_q <= bitn_q + 4'h1;
        if (scl_rise & bitn_q == 4'h8 & dir_q & sync_q.sda) nack_q <= 1'b1;
        if (scl_fall & dir_q & bitn_q < 4'h8) begin
          drive_sda_q <= ~sh_q[7];
          sh_q        <= {sh_q[6:0], 1'b1};
        end
        // acknowledge slot: receiver pulls, transmitter lets go
        if (byte_rcvd) begin
          drive_sda_q <= ~dir_q & ack_me;
          if (addr_done) addr_phase_q <= 1'b0;
          if (addr_done & ~mst_q & addr_match) aas_q <= 1'b1;
        end
        if (byte_end) begin
          bitn_q      <= 4'h0;
          rx_q        <= sh_q;
          done_q      <= 1'b1;
          drive_sda_q <= dir_q & ~tx_q[7];
          if (dir_q) sh_q <= {tx_q[6:0], 1'b1};
        end
      end
      if (req_in.rd & req_in.addr == RX_DATA_OFF & ~byte_end) done_q <= 1'b0;
      // master clock generation
      case (st_q)
        ST_IDLE: begin
          drive_scl_q <= 1'b0;
          if (go_start) begin
            st_q        <= ST_START;
            start_req_q <= 1'b1;
          end
        end
        // own start is seen here, so it does not clear the role bits
        ST_START: begin
          if (start_det) begin
            drive_sda_q <= 1'b1;
            start_req_q <= 1'b0;
            st_q        <= ST_BITS;
          end else if (hc_tick) begin
            drive_sda_q <= 1'b1;
          end
        end
        ST_BITS: begin
          if (~mst_q & ~al_pend_q) st_q <= ST_IDLE;
          else if (hc_tick & at_boundary) st_q <= ST_STOP;
          else if (hc_tick) drive_scl_q <= ~drive_scl_q;
        end
        ST_STOP: if (hc_tick) begin
          if (drive_scl_q & ~drive_sda_q) drive_sda_q <= 1'b1;
          else if (drive_scl_q) drive_scl_q <= 1'b0;
          else begin
            drive_sda_q <= 1'b0;
            stop_req_q  <= 1'b0;
            st_q        <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      if (kill) begin
        st_q        <= ST_IDLE;
        drive_scl_q <= 1'b0;
        drive_sda_q <= 1'b0;
        start_req_q <= 1'b0;
        stop_req_q  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts and register reads
  // ----------------------------------------------------------------
  wire [EV_W-1:0] ev = {blocked, byte_end, al_event, stop_det, start_det};
  wire clr_ist = req_in.wr & (req_in.addr == IRQ_CLR_OFF);
  wire [7:0] main_rd = {mst_q, dir_q, start_req_q, stop_req_q, 4'h0};
  wire [7:0] aux_rd  = {5'h00, free_q, 1'b0, en_q};
  wire [7:0] stat_rd = {2'b00, nack_q, done_q, prot_q, al_q, aas_q, bb_q};

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      en_q    <= AUX_RESET[EN_BIT_POS];
      free_q  <= AUX_RESET[FREE_BIT_POS];
      own_q   <= OWN_ADDR_RESET;
      tx_q    <= 8'h00;
      ist_q   <= '0;
      ien_q   <= '0;
      rdata_q <= 8'h00;
    end else if (clk_en_in) begin
      if (wr_aux) begin
        en_q   <= req_in.wdata[EN_BIT_POS] & ~req_in.wdata[RST_BIT_POS];
        free_q <= req_in.wdata[FREE_BIT_POS];
      end
      if (req_in.wr & req_in.addr == OWN_ADDR_OFF) own_q <= req_in.wdata[6:0];
      if (req_in.wr & req_in.addr == TX_DATA_OFF) tx_q <= req_in.wdata;
      if (req_in.wr & req_in.addr == IRQ_EN_OFF) ien_q <= req_in.wdata[EV_W-1:0];
      ist_q <= (ist_q & ~(clr_ist ? req_in.wdata[EV_W-1:0] : '0)) | ev;
      rdata_q <= 8'h00;
      if (req_in.rd) begin
        case (req_in.addr)
          MAIN_CTRL_OFF: rdata_q <= main_rd;
          AUX_CTRL_OFF:  rdata_q <= aux_rd;
          STATUS_OFF:    rdata_q <= stat_rd;
          IRQ_STAT_OFF:  rdata_q <= {3'b000, ist_q};
          IRQ_EN_OFF:    rdata_q <= {3'b000, ien_q};
          OWN_ADDR_OFF:  rdata_q <= {1'b0, own_q};
          TX_DATA_OFF:   rdata_q <= tx_q;
          RX_DATA_OFF:   rdata_q <= rx_q;
          default:       rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign rdata_out         = rdata_q;
  assign irq_out           = |(ist_q & ien_q);
  assign pins_oe_n_out.scl = ~drive_scl_q;
  assign pins_oe_n_out.sda = ~drive_sda_q;

endmodule // role_dir_ctrl

// File: dv/role_dir_ctrl_checker.sv
// checker: port-level assertions for role_dir_ctrl
// assumes: bound to the design top, one clock domain
`timescale 1ns/1ps
module role_dir_ctrl_checker
  import role_dir_pkg::*;
(
  input wire logic                    clock_in,
  input wire logic                    reset_in,
  input wire logic                    clk_en_in,
  input wire role_dir_pkg::reg_req_t  req_in,
  input wire logic [DATA_W-1:0]       rdata_out,
  input wire role_dir_pkg::bus_pins_t pins_in,
  input wire role_dir_pkg::bus_pins_t pins_oe_n_out,
  input wire logic                    irq_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  wire take_wr = clk_en_in && req_in.wr;
  wire take_rd = clk_en_in && req_in.rd;
  wire aux_wr  = take_wr && req_in.addr == AUX_CTRL_OFF;
  // ----------
  // assertions
  // ----------
  a_reset_quiet: assert property ($fell(reset_in) |-> pins_oe_n_out == 2'b11 && !irq_out && rdata_out == '0)
    else $error("outputs not quiet after reset");
  a_rdata_quiet: assert property (clk_en_in && !req_in.rd |=> rdata_out == '0)
    else $error("read data without read");
  a_unmapped_zero: assert property (take_rd && req_in.addr > RX_DATA_OFF |=> rdata_out == '0)
    else $error("unmapped read not zero");
  a_event_width: assert property (take_rd && req_in.addr == IRQ_STAT_OFF |=> rdata_out[7:EV_W] == '0)
    else $error("event status upper bits set");
  a_irq_masked: assert property (take_wr && req_in.addr == IRQ_EN_OFF && req_in.wdata[EV_W-1:0] == '0 |=> !irq_out)
    else $error("interrupt while all masked");
  a_disable_release: assert property (aux_wr && !req_in.wdata[EN_BIT_POS] |-> ##[1:4] pins_oe_n_out == 2'b11)
    else $error("pins driven after disable");
  a_softrst_release: assert property (aux_wr && req_in.wdata[RST_BIT_POS] |-> ##[1:4] pins_oe_n_out == 2'b11)
    else $error("pins driven after soft reset");
  a_freeze_hold: assert property (!clk_en_in |=> $stable(pins_oe_n_out) && $stable(irq_out) && $stable(rdata_out))
    else $error("state moved while frozen");
  c_start: cover property (take_wr && req_in.addr == MAIN_CTRL_OFF && req_in.wdata == 8'hA0);
  c_irq: cover property ($rose(irq_out));
  c_drive: cover property ($fell(pins_oe_n_out.scl));
endmodule // role_dir_ctrl_checker

bind role_dir_ctrl role_dir_ctrl_checker i_checker (.clock_in(clock_in), .reset_in(reset_in),
  .clk_en_in(clk_en_in), .req_in(req_in), .rdata_out(rdata_out), .pins_in(pins_in),
  .pins_oe_n_out(pins_oe_n_out), .irq_out(irq_out));

// File: dv/bus_peer.sv
// model: another master on the serial bus
// assumes: bench resolves the wire with pull-ups; enables low pull the wire
`timescale 1ns/1ps
module bus_peer (
  output logic scl_oe_n_out,
  output logic sda_oe_n_out
);
  time half = 80;
  initial begin
    scl_oe_n_out = 1'b1;
    sda_oe_n_out = 1'b1;
  end
  task automatic start_cond();
    sda_oe_n_out = 1'b0;
    #half scl_oe_n_out = 1'b0;
    #half;
  endtask
  // ninth slot released for the acknowledge
  task automatic put_byte(input logic [7:0] b);
    for (int i = 0; i < 9; i++) begin
      #(half / 2) sda_oe_n_out = (i < 8) ? b[7 - i] : 1'b1;
      #(half / 2) scl_oe_n_out = 1'b1;
      #half scl_oe_n_out = 1'b0;
    end
  endtask
  task automatic stop_cond();
    #(half / 2) sda_oe_n_out = 1'b0;
    #half scl_oe_n_out = 1'b1;
    #half sda_oe_n_out = 1'b1;
    #half;
  endtask
endmodule // bus_peer

// File: dv/role_dir_ctrl_test.sv
// bench: register, master and slave traffic for role_dir_ctrl
// assumes: bus_peer on an open-drain wire with pull-ups
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s: expected %h, seen %h", n, e, g); end end
module role_dir_ctrl_test;
  import role_dir_pkg::*;
  logic        clock_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        clk_en_in = 1'b1;
  reg_req_t    req_in = '0;
  logic [7:0]  rdata_out;
  bus_pins_t   pins_oe_n_out;
  bus_pins_t   pins;
  logic        irq_out;
  logic        peer_scl_oe_n;
  logic        peer_sda_oe_n;
  logic [7:0]  d;
  int          err_count = 0;
  int          check_count = 0;
  int          scl_pulls = 0;
  logic [11:0] rows [0:6] = '{12'h000, 12'h100, 12'h200, 12'h300, 12'h400, 12'h650, 12'hF00};
  always #10 clock_in = ~clock_in;
  assign pins.scl = pins_oe_n_out.scl & peer_scl_oe_n;
  assign pins.sda = pins_oe_n_out.sda & peer_sda_oe_n;
  always @(negedge pins_oe_n_out.scl) scl_pulls++;
  role_dir_ctrl #(.HALF_CYC(4)) i_role_dir_ctrl (.clock_in(clock_in), .reset_in(reset_in),
    .clk_en_in(clk_en_in), .req_in(req_in), .rdata_out(rdata_out), .pins_in(pins),
    .pins_oe_n_out(pins_oe_n_out), .irq_out(irq_out));
  bus_peer i_bus_peer (.scl_oe_n_out(peer_scl_oe_n), .sda_oe_n_out(peer_sda_oe_n));
  // ----------
  // bus tasks
  // ----------
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_in);
    req_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clock_in);
    req_in <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock_in);
    req_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_in);
    req_in <= '0;
    @(negedge clock_in);
    v = rdata_out;
  endtask
  task automatic wait_bit(input logic [3:0] a, input int b, input logic v);
    for (int n = 0; n < 500; n++) begin
      rd(a, d);
      if (d[b] === v) return;
    end
    err_count++;
    $display("unexpected wait on %h bit %0d", a, b);
    test_done();
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------
  // sequence
  // ----------
  initial begin
    repeat (12) @(posedge clock_in);
    reset_in <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i][11:8], d);
      `CHK("reset value", rows[i][7:0], d)
    end
    @(posedge clock_in);
    clk_en_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    clk_en_in <= 1'b1;
    wr(AUX_CTRL_OFF, 8'h01);
    wr(IRQ_EN_OFF, 8'h1F);
    wr(TX_DATA_OFF, 8'hA5);
    scl_pulls = 0;
    wr(MAIN_CTRL_OFF, 8'hA0);
    rd(MAIN_CTRL_OFF, d);
    `CHK("role on start", 2'b11, d[7:6])
    rd(STATUS_OFF, d);
    `CHK("busy on start", 1'b1, d[BB_POS])
    wait_bit(IRQ_STAT_OFF, EV_BYTE, 1'b1);
    `CHK("master clock pulses", 1'b1, scl_pulls >= 9)
    wr(MAIN_CTRL_OFF, 8'h10);
    wait_bit(STATUS_OFF, BB_POS, 1'b0);
    rd(MAIN_CTRL_OFF, d);
    `CHK("role after stop", 2'b00, d[7:6])
    `CHK("event interrupt", 1'b1, irq_out)
    wr(IRQ_EN_OFF, 8'h00);
    @(negedge clock_in);
    `CHK("interrupt masked", 1'b0, irq_out)
    wr(IRQ_EN_OFF, 8'h1F);
    wr(IRQ_CLR_OFF, 8'h1F);
    @(negedge clock_in);
    `CHK("interrupt cleared", 1'b0, irq_out)
    for (int rw = 0; rw < 2; rw++) begin
      scl_pulls = 0;
      i_bus_peer.half = rw ? 80 : 240;
      i_bus_peer.start_cond();
      wr(MAIN_CTRL_OFF, 8'hA0);
      rd(IRQ_STAT_OFF, d);
      `CHK("blocked start event", 1'b1, d[EV_BLOCKED])
      rd(MAIN_CTRL_OFF, d);
      `CHK("role when blocked", 2'b00, d[7:6])
      i_bus_peer.put_byte({7'h50, rw[0]});
      rd(MAIN_CTRL_OFF, d);
      `CHK("slave direction", {1'b0, rw[0]}, d[7:6])
      i_bus_peer.put_byte(8'hFF);
      rd(MAIN_CTRL_OFF, d);
      `CHK("direction after data", 2'b00, d[7:6])
      i_bus_peer.stop_cond();
      `CHK("slave leaves clock", 0, scl_pulls)
      wr(IRQ_CLR_OFF, 8'h1F);
    end
    wr(MAIN_CTRL_OFF, 8'hA0);
    repeat (30) @(posedge clock_in);
    wr(AUX_CTRL_OFF, 8'h00);
    rd(MAIN_CTRL_OFF, d);
    `CHK("role after disable", 2'b00, d[7:6])
    `CHK("pins after disable", 2'b11, pins_oe_n_out)
    wr(AUX_CTRL_OFF, 8'h01);
    wr(AUX_CTRL_OFF, 8'h03);
    rd(AUX_CTRL_OFF, d);
    `CHK("soft reset disables", 2'b00, d[1:0])
    @(posedge clock_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(IRQ_EN_OFF, d);
    `CHK("enable after reset", 8'h00, d)
    test_done();
  end
  initial begin
    #1500us;
    err_count++;
    test_done();
  end
endmodule // role_dir_ctrl_test
